/* src/cie_device.sv */
// Device end: end-of-interrupt and deactivate completion logic
//
// The implementer's own choices: the address map and the strobed register port.
module cie_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link to the processing element
  cie_if.dev lnk,
  // Platform presence
  input wire logic top_present_i,
  input wire logic hyp_enabled_i,
  input wire logic id24_i,
  input wire logic sei_supported_i,
  // Interface enables, bit n for level n+1
  input wire logic [2:0] sre_i,
  // Completion mode bits
  input wire logic completion_mode_bit_i,
  input wire logic completion_mode_top_i,
  input wire logic completion_mode_secure_low_i,
  input wire logic completion_mode_nonsecure_low_i,
  // Hypervisor trap and override controls
  input wire logic deactivate_trap_i,
  input wire logic common_trap_i,
  input wire logic trap_all_group0_i,
  input wire logic trap_all_group1_i,
  input wire logic fast_irq_override_i,
  input wire logic normal_irq_override_i,
  // Secure monitor routing and debug
  input wire logic mon_fiq_route_i,
  input wire logic mon_irq_route_i,
  input wire logic secure_debug_disable_i,
  // Priority drop command
  output logic drop_valid_o,
  output logic [`CIE_ID_W-1:0] drop_id_o,
  output logic drop_group1_o,
  // Distributor deactivate command
  output logic deact_valid_o,
  output logic [`CIE_ID_W-1:0] deact_id_o,
  // Virtual register write
  output logic virt_valid_o,
  output cie_pkg::cie_reg_t virt_reg_o,
  output logic [`CIE_DATA_W-1:0] virt_data_o,
  // Exceptions and system error
  output logic trap_valid_o,
  output logic [1:0] trap_el_o,
  output logic [5:0] trap_class_o,
  output logic undef_valid_o,
  output logic sei_valid_o
);
  // ============================================================
  // All state of the device end
  typedef struct packed {
    logic resp_valid;
    cie_pkg::cie_outcome_t resp_outcome;
    logic [1:0] resp_el;
    logic drop_valid;
    logic [`CIE_ID_W-1:0] drop_id;
    logic drop_group1;
    logic deact_valid;
    logic [`CIE_ID_W-1:0] deact_id;
    logic virt_valid;
    cie_pkg::cie_reg_t virt_reg;
    logic [`CIE_DATA_W-1:0] virt_data;
    logic trap_valid;
    logic [1:0] trap_el;
    logic undef_valid;
    logic sei_valid;
  } cie_dev_state_t;

  cie_dev_state_t st_q; // Registered state
  cie_dev_state_t st_d; // Next state

  // ============================================================
  // Access verdict
  cie_pkg::cie_outcome_t chk_outcome; // Outcome from the level checks
  logic [1:0] chk_el; // Level an exception goes to

  cie_access_check u_check (
    .reg_i(lnk.req_reg),
    .el_i(lnk.req_el),
    .halted_i(lnk.req_halted),
    .top_present_i(top_present_i),
    .hyp_enabled_i(hyp_enabled_i),
    .sre_i(sre_i),
    .sdd_i(secure_debug_disable_i),
    .deact_trap_i(deactivate_trap_i),
    .common_trap_i(common_trap_i),
    .trap_all0_i(trap_all_group0_i),
    .trap_all1_i(trap_all_group1_i),
    .fiq_ovr_i(fast_irq_override_i),
    .irq_ovr_i(normal_irq_override_i),
    .mon_fiq_i(mon_fiq_route_i),
    .mon_irq_i(mon_irq_route_i),
    .outcome_o(chk_outcome),
    .el_o(chk_el)
  );

  // ============================================================
  // Identifier decode
  logic [`CIE_ID_W-1:0] req_id; // Identifier with unimplemented bits cleared
  logic id_special; // Identifier falls in the reserved special range
  logic mode_split; // Selected completion mode, 1 splits drop from deactivate

  // Narrow parts ignore bits 23:16 and all of 63:24
  always_comb begin
    req_id = lnk.req_data[`CIE_ID_W-1:0];
    if (!id24_i) begin
      req_id[`CIE_ID_W-1:`CIE_ID16_MSB+1] = '0;
    end
  end

  assign id_special = (req_id >= `CIE_SPECIAL_LO) && (req_id <= `CIE_SPECIAL_HI);

  // Mode bit selection by level and security state
  always_comb begin
    if (!top_present_i) begin
      mode_split = completion_mode_bit_i;
    end else if (lnk.req_el == 2'h3) begin
      mode_split = completion_mode_top_i;
    end else if (lnk.req_secure) begin
      mode_split = completion_mode_secure_low_i;
    end else begin
      mode_split = completion_mode_nonsecure_low_i;
    end
  end

  // ============================================================
  // Next state: one answer and at most a drop plus a deactivate per accepted write, all pulses one cycle
  always_comb begin
    st_d = st_q;
    st_d.resp_valid = 1'b0;
    st_d.drop_valid = 1'b0;
    st_d.deact_valid = 1'b0;
    st_d.virt_valid = 1'b0;
    st_d.trap_valid = 1'b0;
    st_d.undef_valid = 1'b0;
    st_d.sei_valid = 1'b0;
    if (lnk.req_valid) begin
      // Every write is answered exactly once
      st_d.resp_valid = 1'b1;
      st_d.resp_outcome = chk_outcome;
      st_d.resp_el = chk_el;
      unique case (chk_outcome)
        cie_pkg::CIE_OUT_TRAP: begin
          st_d.trap_valid = 1'b1;
          st_d.trap_el = chk_el;
        end
        cie_pkg::CIE_OUT_UNDEF: begin
          st_d.undef_valid = 1'b1;
        end
        cie_pkg::CIE_OUT_VIRT: begin
          // Virtual copy sees the raw word; its own logic decodes it
          st_d.virt_valid = 1'b1;
          st_d.virt_reg = lnk.req_reg;
          st_d.virt_data = lnk.req_data;
        end
        default: begin
          if (lnk.req_reg == cie_pkg::CIE_REG_DEACT) begin
            if (mode_split) begin
              // No priority drop here, so an early write leaves it set
              st_d.deact_valid = 1'b1;
              st_d.deact_id = req_id;
            end else begin
              st_d.resp_outcome = cie_pkg::CIE_OUT_IGNORED;
              st_d.sei_valid = sei_supported_i;
            end
          end else if (id_special) begin
            st_d.resp_outcome = cie_pkg::CIE_OUT_IGNORED;
          end else begin
            st_d.drop_valid = 1'b1;
            st_d.drop_id = req_id;
            st_d.drop_group1 = (lnk.req_reg == cie_pkg::CIE_REG_EOI1);
            if (!mode_split) begin
              st_d.deact_valid = 1'b1;
              st_d.deact_id = req_id;
            end
          end
        end
      endcase
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outputs, all from flip-flops except the constant trap class
  assign lnk.resp_valid = st_q.resp_valid;
  assign lnk.resp_outcome = st_q.resp_outcome;
  assign lnk.resp_el = st_q.resp_el;
  assign drop_valid_o = st_q.drop_valid;
  assign drop_id_o = st_q.drop_id;
  assign drop_group1_o = st_q.drop_group1;
  assign deact_valid_o = st_q.deact_valid;
  assign deact_id_o = st_q.deact_id;
  assign virt_valid_o = st_q.virt_valid;
  assign virt_reg_o = st_q.virt_reg;
  assign virt_data_o = st_q.virt_data;
  assign trap_valid_o = st_q.trap_valid;
  assign trap_el_o = st_q.trap_el;
  // Syndrome class is the same for every trap of this path
  assign trap_class_o = `CIE_TRAP_CLASS;
  assign undef_valid_o = st_q.undef_valid;
  assign sei_valid_o = st_q.sei_valid;
endmodule // cie_device

/* inc/cie_map.svh */
// Offsets, field positions and widths of the completion path
// Function
// - Split mode: deactivate write deactivates given identifier
// - Identifier bits 23:0, 16 or 24 implemented
// - Mode 0: deactivate write ignored, optional error
// - Early deactivate: distributor deactivates, priority stays
// - Mode 0: completion drops priority and deactivates
// - Mode 1: completion only drops; software deactivates
// - Mode bit chosen by level and security
// - Completion carries last valid acknowledged identifier
// - Completion with special identifier is ignored
// - Group 0 completes through group-0 register
// - Group 1 completes through group-1 register
// - Unprivileged level writes are undefined
// - Interface disabled: trap to current level, 0x18
// - Deactivate or common trap sends deactivate hypervisor-ward
// - Group-0 trap-all sends group-0 completion hypervisor-ward
// - Group-1 trap-all sends group-1 completion hypervisor-ward
// - Override routing bits redirect to virtual register
// - Monitor fast routing traps group-0 completion upward
// - Both monitor routing bits trap deactivate upward
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

// ============================================================
// Register word layout
`define CIE_DATA_W 64
`define CIE_ID_W 24
`define CIE_ID16_MSB 15
`define CIE_SPECIAL_LO 24'h0003fc
`define CIE_SPECIAL_HI 24'h0003ff
`define CIE_TRAP_CLASS 6'h18
// 1 puts halted-debug undefined ahead of the enable, hypervisor and override checks
`define CIE_TOP_TRAP_PRIO_SDD 1'b0

// ============================================================
// Host command port offsets and fields
`define CIE_ADDR_W 4
`define CIE_HOST_CMD 4'h0
`define CIE_HOST_ID 4'h1
`define CIE_HOST_CTX 4'h2
`define CIE_HOST_ACK 4'h3
`define CIE_HOST_STAT 4'h4
`define CIE_CMD_DEACT_BIT 0
`define CIE_CMD_GROUP_BIT 1
`define CIE_CTX_SEC_BIT 2
`define CIE_CTX_HALT_BIT 3
`define CIE_STAT_BUSY_BIT 8
`define CIE_STAT_ACKV_BIT 9

`endif

/* inc/cie_pkg.sv */
// Types shared by both ends of the completion path
`include "cie_map.svh"
package cie_pkg;
  // ============================================================
  // Which write-only register a request targets
  typedef enum logic [1:0] {
    CIE_REG_DEACT = 2'h0,
    CIE_REG_EOI0 = 2'h1,
    CIE_REG_EOI1 = 2'h2
  } cie_reg_t;

  // How the device disposed of a request
  typedef enum logic [2:0] {
    CIE_OUT_PHYS = 3'h0,
    CIE_OUT_VIRT = 3'h1,
    CIE_OUT_TRAP = 3'h2,
    CIE_OUT_UNDEF = 3'h3,
    CIE_OUT_IGNORED = 3'h4
  } cie_outcome_t;

  // Host sequencer states, Gray along idle, request, wait
  typedef enum logic [1:0] {
    CIE_H_IDLE = 2'h0,
    CIE_H_REQ = 2'h1,
    CIE_H_WAIT = 2'h3
  } cie_hstate_t;
endpackage

/* inc/cie_if.sv */
// Link between the processing element and the completion device
interface cie_if;
  // Request from the processing element
  logic req_valid;
  cie_pkg::cie_reg_t req_reg;
  logic [`CIE_DATA_W-1:0] req_data;
  logic [1:0] req_el;
  logic req_secure;
  logic req_halted;
  // Answer from the device
  logic resp_valid;
  cie_pkg::cie_outcome_t resp_outcome;
  logic [1:0] resp_el;

  modport dev (
    input req_valid, req_reg, req_data, req_el, req_secure, req_halted,
    output resp_valid, resp_outcome, resp_el
  );
  modport host (
    output req_valid, req_reg, req_data, req_el, req_secure, req_halted,
    input resp_valid, resp_outcome, resp_el
  );
endinterface

/* src/cie_access_check.sv */
// Exception-level access checks for the three write-only registers
module cie_access_check (
  // Request context
  input wire cie_pkg::cie_reg_t reg_i,
  input wire logic [1:0] el_i,
  input wire logic halted_i,
  // Platform configuration
  input wire logic top_present_i,
  input wire logic hyp_enabled_i,
  input wire logic [2:0] sre_i,
  input wire logic sdd_i,
  input wire logic deact_trap_i,
  input wire logic common_trap_i,
  input wire logic trap_all0_i,
  input wire logic trap_all1_i,
  input wire logic fiq_ovr_i,
  input wire logic irq_ovr_i,
  input wire logic mon_fiq_i,
  input wire logic mon_irq_i,
  // Verdict
  output cie_pkg::cie_outcome_t outcome_o,
  output logic [1:0] el_o
);
  // ============================================================
  // Per-register selection of trap, override and routing terms
  logic hyp_trap;
  logic ovr;
  logic route;
  logic sdd_undef;

  // Terms depend on the register written
  always_comb begin
    unique case (reg_i)
      cie_pkg::CIE_REG_EOI0: begin
        hyp_trap = trap_all0_i;
        ovr = fiq_ovr_i;
        route = mon_fiq_i;
      end
      cie_pkg::CIE_REG_EOI1: begin
        hyp_trap = trap_all1_i;
        ovr = irq_ovr_i;
        route = mon_irq_i;
      end
      default: begin
        hyp_trap = deact_trap_i | common_trap_i;
        ovr = fiq_ovr_i | irq_ovr_i;
        route = mon_fiq_i & mon_irq_i;
      end
    endcase
  end

  // Halted debug with secure debug off makes the upward trap undefined
  assign sdd_undef = halted_i & top_present_i & sdd_i;

  // ============================================================
  // Priority chain, first match wins
  always_comb begin
    outcome_o = cie_pkg::CIE_OUT_PHYS;
    el_o = el_i;
    unique case (el_i)
      2'h0: begin
        outcome_o = cie_pkg::CIE_OUT_UNDEF;
      end
      2'h1, 2'h2: begin
        if (sdd_undef && `CIE_TOP_TRAP_PRIO_SDD && route) begin
          outcome_o = cie_pkg::CIE_OUT_UNDEF;
        end else if (!sre_i[el_i-2'h1]) begin
          outcome_o = cie_pkg::CIE_OUT_TRAP;
        end else if (el_i == 2'h1 && hyp_enabled_i && hyp_trap) begin
          outcome_o = cie_pkg::CIE_OUT_TRAP;
          el_o = 2'h2;
        end else if (el_i == 2'h1 && hyp_enabled_i && ovr) begin
          outcome_o = cie_pkg::CIE_OUT_VIRT;
        end else if (top_present_i && route) begin
          // Halted debug with secure debug disabled cannot trap into the monitor
          outcome_o = sdd_undef ? cie_pkg::CIE_OUT_UNDEF
                                : cie_pkg::CIE_OUT_TRAP;
          el_o = 2'h3;
        end
      end
      default: begin
        if (!sre_i[2]) begin
          outcome_o = cie_pkg::CIE_OUT_TRAP;
        end
      end
    endcase
  end
endmodule // cie_access_check

/* src/cie_host.sv */
// Processing element end: issues completion writes on software order
module cie_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Software port
  input wire logic [`CIE_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Link to the device
  cie_if.host lnk
);
  // ============================================================
  // All state of the host end
  typedef struct packed {
    cie_pkg::cie_hstate_t fsm;
    cie_pkg::cie_reg_t reg_sel;
    logic [`CIE_ID_W-1:0] id;
    logic [`CIE_ID_W-1:0] ack_id;
    logic ack_valid;
    logic [1:0] el;
    logic secure;
    logic halted;
    cie_pkg::cie_outcome_t outcome;
    logic [1:0] out_el;
    logic [31:0] rdata;
  } cie_host_state_t;

  cie_host_state_t st_q; // Registered state
  cie_host_state_t st_d; // Next state
  logic ack_special; // Written acknowledge value is a special identifier

  assign ack_special = (wdata_i[`CIE_ID_W-1:0] >= `CIE_SPECIAL_LO)
                    && (wdata_i[`CIE_ID_W-1:0] <= `CIE_SPECIAL_HI);

  // ============================================================
  // Next state; commands while busy are dropped, not queued
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    unique case (st_q.fsm)
      cie_pkg::CIE_H_IDLE: ;
      cie_pkg::CIE_H_REQ: st_d.fsm = cie_pkg::CIE_H_WAIT;
      cie_pkg::CIE_H_WAIT: begin
        if (lnk.resp_valid) begin
          st_d.fsm = cie_pkg::CIE_H_IDLE;
          st_d.outcome = lnk.resp_outcome;
          st_d.out_el = lnk.resp_el;
          // Consumed; a same-cycle ack write wins
          if (st_q.reg_sel != cie_pkg::CIE_REG_DEACT) begin
            st_d.ack_valid = 1'b0;
          end
        end
      end
      default: st_d.fsm = cie_pkg::CIE_H_IDLE;
    endcase
    if (wr_i) begin
      unique case (addr_i)
        `CIE_HOST_CMD: begin
          if (st_q.fsm == cie_pkg::CIE_H_IDLE) begin
            st_d.fsm = cie_pkg::CIE_H_REQ;
            if (wdata_i[`CIE_CMD_DEACT_BIT]) begin
              st_d.reg_sel = cie_pkg::CIE_REG_DEACT;
            end else if (wdata_i[`CIE_CMD_GROUP_BIT]) begin
              st_d.reg_sel = cie_pkg::CIE_REG_EOI1;
            end else begin
              st_d.reg_sel = cie_pkg::CIE_REG_EOI0;
            end
          end
        end
        `CIE_HOST_ID: st_d.id = wdata_i[`CIE_ID_W-1:0];
        `CIE_HOST_CTX: begin
          st_d.el = wdata_i[1:0];
          st_d.secure = wdata_i[`CIE_CTX_SEC_BIT];
          st_d.halted = wdata_i[`CIE_CTX_HALT_BIT];
        end
        `CIE_HOST_ACK: begin
          // Only a non-special acknowledge counts as valid
          if (!ack_special) begin
            st_d.ack_id = wdata_i[`CIE_ID_W-1:0];
            st_d.ack_valid = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `CIE_HOST_ID: st_d.rdata = {8'h00, st_q.id};
        `CIE_HOST_CTX: st_d.rdata = {28'h0000000, st_q.halted, st_q.secure, st_q.el};
        `CIE_HOST_ACK: st_d.rdata = {8'h00, st_q.ack_id};
        `CIE_HOST_STAT: begin
          st_d.rdata[2:0] = st_q.outcome;
          st_d.rdata[5:4] = st_q.out_el;
          st_d.rdata[`CIE_STAT_BUSY_BIT] = (st_q.fsm != cie_pkg::CIE_H_IDLE);
          st_d.rdata[`CIE_STAT_ACKV_BIT] = st_q.ack_valid;
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Link drive: completions carry the acknowledged identifier
  assign lnk.req_valid = (st_q.fsm == cie_pkg::CIE_H_REQ);
  assign lnk.req_reg = st_q.reg_sel;
  assign lnk.req_data = {40'h0000000000,
    (st_q.reg_sel == cie_pkg::CIE_REG_DEACT) ? st_q.id : st_q.ack_id};
  assign lnk.req_el = st_q.el;
  assign lnk.req_secure = st_q.secure;
  assign lnk.req_halted = st_q.halted;
  assign rdata_o = st_q.rdata;
endmodule // cie_host

/* testbench/cie_link_sva.sv */
// Concurrent checks on the link between the two ends of the completion path
`include "cie_map.svh"
module cie_link_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Request side of the link
  input wire logic req_valid,
  input wire cie_pkg::cie_reg_t req_reg,
  input wire logic [`CIE_DATA_W-1:0] req_data,
  input wire logic [1:0] req_el,
  input wire logic req_secure,
  input wire logic req_halted,
  // Answer side of the link
  input wire logic resp_valid,
  input wire cie_pkg::cie_outcome_t resp_outcome,
  input wire logic [1:0] resp_el
);
  // ============================================================
  // Clocking: one domain, so defaults cover every property
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ============================================================
  // Handshake: every request answered next cycle, nothing stray
  property p_answer;
    req_valid |=> resp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_no_stray;
    resp_valid |-> $past(req_valid);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without request");
  // Host issues one request per command, never two in a row
  property p_single;
    req_valid |=> !req_valid;
  endproperty
  a_single: assert property (p_single) else $error("request repeated");

  // ============================================================
  // Access checks by level
  property p_user_undef;
    req_valid && req_el == 2'h0 |=> resp_outcome == cie_pkg::CIE_OUT_UNDEF;
  endproperty
  a_user_undef: assert property (p_user_undef) else $error("user write not undef");
  // Top level can only reach the register or trap to itself
  property p_top_level;
    req_valid && req_el == 2'h3 |=> resp_el == 2'h3 &&
      resp_outcome inside {cie_pkg::CIE_OUT_PHYS, cie_pkg::CIE_OUT_TRAP,
                           cie_pkg::CIE_OUT_IGNORED};
  endproperty
  a_top_level: assert property (p_top_level) else $error("top level misrouted");
  property p_virt_low;
    resp_valid && resp_outcome == cie_pkg::CIE_OUT_VIRT |-> $past(req_el) == 2'h1;
  endproperty
  a_virt_low: assert property (p_virt_low) else $error("virtual write off level 1");
  // Undefined only from user level or halted debug
  property p_undef_cause;
    resp_valid && resp_outcome == cie_pkg::CIE_OUT_UNDEF |->
      $past(req_el) == 2'h0 || $past(req_halted);
  endproperty
  a_undef_cause: assert property (p_undef_cause) else $error("undef without cause");
  // A trap never goes to a lower level than the requester
  property p_trap_up;
    resp_valid && resp_outcome == cie_pkg::CIE_OUT_TRAP |->
      resp_el >= $past(req_el) && resp_el != 2'h0;
  endproperty
  a_trap_up: assert property (p_trap_up) else $error("trap to lower level");
  // Ignored only for a deactivate or a special identifier
  property p_ignored;
    resp_valid && resp_outcome == cie_pkg::CIE_OUT_IGNORED |->
      $past(req_reg) == cie_pkg::CIE_REG_DEACT ||
      $past(req_data[15:0]) inside {[16'h03fc:16'h03ff]};
  endproperty
  a_ignored: assert property (p_ignored) else $error("write ignored without cause");

  // ============================================================
  // Main scenarios reached
  c_trap: cover property (resp_valid && resp_outcome == cie_pkg::CIE_OUT_TRAP);
  c_virt: cover property (resp_valid && resp_outcome == cie_pkg::CIE_OUT_VIRT);
  c_ign: cover property (resp_valid && resp_outcome == cie_pkg::CIE_OUT_IGNORED);
  c_undef: cover property (resp_valid && resp_outcome == cie_pkg::CIE_OUT_UNDEF);
endmodule // cie_link_sva

/* testbench/tb.sv */
// Self-checking bench: host and device joined over the link
`include "cie_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // Software port, config and device commands
  logic clk, rst_b, wr, rd;
  logic [`CIE_ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, st, c;
  // Config: 0 top,1 hyp,2 id24,3 sei,6:4 enables,10:7 modes,14:11 traps,
  // 16:15 overrides,18:17 monitor routing,19 debug disable
  logic [19:0] cfg;
  logic drop_v, drop_g, deact_v, virt_v, trap_v, undef_v, sei_v, ackv;
  logic [23:0] drop_id, deact_id, ack_m;
  cie_pkg::cie_reg_t virt_reg;
  logic [1:0] trap_el;
  logic [5:0] trap_cls;
  int miscompares, check_count;
  cie_if lnk ();
  cie_host cie_host_i (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lnk(lnk));
  cie_device cie_device_i (.clk_i(clk), .rst_b_i(rst_b), .lnk(lnk),
    .top_present_i(cfg[0]), .hyp_enabled_i(cfg[1]), .id24_i(cfg[2]), .sei_supported_i(cfg[3]),
    .sre_i(cfg[6:4]), .completion_mode_bit_i(cfg[7]), .completion_mode_top_i(cfg[8]),
    .completion_mode_secure_low_i(cfg[9]), .completion_mode_nonsecure_low_i(cfg[10]),
    .deactivate_trap_i(cfg[11]), .common_trap_i(cfg[12]), .trap_all_group0_i(cfg[13]),
    .trap_all_group1_i(cfg[14]), .fast_irq_override_i(cfg[15]),
    .normal_irq_override_i(cfg[16]), .mon_fiq_route_i(cfg[17]), .mon_irq_route_i(cfg[18]),
    .secure_debug_disable_i(cfg[19]), .drop_valid_o(drop_v), .drop_id_o(drop_id),
    .drop_group1_o(drop_g), .deact_valid_o(deact_v), .deact_id_o(deact_id),
    .virt_valid_o(virt_v), .virt_reg_o(virt_reg), .virt_data_o(), .trap_valid_o(trap_v),
    .trap_el_o(trap_el), .trap_class_o(trap_cls), .undef_valid_o(undef_v),
    .sei_valid_o(sei_v));
  cie_link_sva cie_link_sva_i (.clk_i(clk), .rst_b_i(rst_b), .req_valid(lnk.req_valid),
    .req_reg(lnk.req_reg), .req_data(lnk.req_data), .req_el(lnk.req_el),
    .req_secure(lnk.req_secure), .req_halted(lnk.req_halted), .resp_valid(lnk.resp_valid),
    .resp_outcome(lnk.resp_outcome), .resp_el(lnk.resp_el));

  // ============================================================
  // Clock and watchdog; the watchdog span is far above the test length
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  // ============================================================
  // Comparison, bus cycles and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe drops one edge later, so back-to-back calls leave a gap
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Expected disposition of a write, by level and routing
  function automatic logic special(input logic [23:0] v);
    return v >= 24'h0003fc && v <= 24'h0003ff;
  endfunction
  function automatic void model(input logic [1:0] r, el, input logic h,
                                output cie_pkg::cie_outcome_t o, output logic [1:0] e);
    logic tr, vr, mr;
    tr = r == 2'h0 ? cfg[11] | cfg[12] : r == 2'h1 ? cfg[13] : cfg[14];
    vr = r == 2'h0 ? cfg[15] | cfg[16] : r == 2'h1 ? cfg[15] : cfg[16];
    mr = cfg[0] & (r == 2'h0 ? cfg[17] & cfg[18] : r == 2'h1 ? cfg[17] : cfg[18]);
    e = el;
    o = cie_pkg::CIE_OUT_PHYS;
    if (el == 2'h0) o = cie_pkg::CIE_OUT_UNDEF;
    else if (!cfg[3 + el]) o = cie_pkg::CIE_OUT_TRAP;
    else if (el == 2'h1 && cfg[1] && tr) begin
      o = cie_pkg::CIE_OUT_TRAP;
      e = 2'h2;
    end else if (el == 2'h1 && cfg[1] && vr) o = cie_pkg::CIE_OUT_VIRT;
    else if (el != 2'h3 && mr) begin
      o = h && cfg[19] ? cie_pkg::CIE_OUT_UNDEF : cie_pkg::CIE_OUT_TRAP;
      e = 2'h3;
    end
  endfunction

  // One completion command through the software port and its checks
  task automatic run(input logic [1:0] r, input logic [3:0] ctx, input logic [23:0] id, ack);
    cie_pkg::cie_outcome_t o;
    logic [1:0] e;
    logic [23:0] v;
    logic m, dv, av;
    int n;
    wr_reg(`CIE_HOST_CTX, {28'h0, ctx});
    wr_reg(`CIE_HOST_ID, {8'h00, id});
    wr_reg(`CIE_HOST_ACK, {8'h00, ack});
    if (!special(ack)) ack_m = ack;
    ackv = !r && (ackv || !special(ack));
    wr_reg(`CIE_HOST_CMD, r == 2'h0 ? 32'h1 : {30'h0, r == 2'h2, 1'b0});
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (lnk.resp_valid !== 1'b1 && n < 4);
    chk(lnk.resp_valid, 1'b1);
    model(r, ctx[1:0], ctx[3], o, e);
    v = r == 2'h0 ? id : ack_m;
    v = cfg[2] ? v : {8'h00, v[15:0]};
    m = !cfg[0] ? cfg[7] : ctx[1:0] == 2'h3 ? cfg[8] : ctx[2] ? cfg[9] : cfg[10];
    if (o == cie_pkg::CIE_OUT_PHYS && (r == 2'h0 ? !m : special(v)))
      o = cie_pkg::CIE_OUT_IGNORED;
    dv = o == cie_pkg::CIE_OUT_PHYS && r != 2'h0;
    av = o == cie_pkg::CIE_OUT_PHYS && (r == 2'h0 || !m);
    chk({drop_v, deact_v}, {dv, av});
    chk(virt_v, o == cie_pkg::CIE_OUT_VIRT);
    chk({trap_v, undef_v}, {o == cie_pkg::CIE_OUT_TRAP, o == cie_pkg::CIE_OUT_UNDEF});
    chk(sei_v, o == cie_pkg::CIE_OUT_IGNORED && r == 2'h0 && cfg[3]);
    if (dv) chk({drop_g, drop_id}, {r == 2'h2, v});
    if (av) chk(deact_id, v);
    if (virt_v) chk(virt_reg, r);
    if (trap_v) chk({trap_el, trap_cls}, {e, `CIE_TRAP_CLASS});
    rd_reg(`CIE_HOST_STAT, st);
    chk({st[9:8], st[5:4], st[2:0]}, {ackv, 1'b0, e, o});
    $display("test done: reg %0d outcome %0d", r, o);
  endtask

  // ============================================================
  // Main sequence: corner cases, then random traffic
  initial begin
    {wr, rd, addr, wdata, cfg, ack_m, c, ackv} = '0;
    rst_b = 1'b0;
    void'($urandom(32'hdf5879c2));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Each register in both modes at level 1, all interfaces enabled, hypervisor off
    for (int k = 0; k < 6; k++) begin
      cfg <= {9'h0, {4{k[0]}}, 7'h7d};
      run(k[2:1], 4'h1, 24'h000100 + k, 24'h000020 + k);
    end
    // Narrow identifiers turn an upper-bit value into a special one
    cfg <= {9'h0, 4'h0, 7'h79};
    run(2'h1, 4'h1, 24'h5, 24'h0103fc);
    // Special acknowledge is refused; the earlier one is reused
    cfg <= {9'h0, 4'h0, 7'h7d};
    run(2'h2, 4'h1, 24'h5, 24'h0003fd);
    run(2'h1, 4'h0, 24'h5, 24'h33);
    cfg <= 20'he007d;
    run(2'h0, 4'ha, 24'h7, 24'h33);
    rd_reg(4'hf, st);
    chk(st, 32'h0);
    repeat (60) begin
      c = $urandom;
      if (c[31]) c[18:11] = 8'h0;
      if (c[30]) c[6:4] = 3'h7;
      if (c[25:24] == 2'h3) c[0] = 1'b1;
      cfg <= c[19:0];
      run(c[23:22] == 2'h3 ? 2'h1 : c[23:22], c[27:24], 24'($urandom),
          c[29] ? 24'h0003fc + c[21:20] : 24'($urandom));
    end
    stop_test();
  end
endmodule // tb
